// ---- logic/osccl_clock_select.sv ----
// Oscillator select, CPU clock divider and clock output pin logic
`timescale 1ns/1ps
// How it works
// - Oscillator type taken from strap, locked
// - Three crystal ranges: low, medium, high
// - RC runs from core clock, divider applies
// - External clock pin rising edges make CPU ticks, divider applies
// - External mode frees output pin as port
// - Clock output only with RC or external
// - Enabled clock output driven, also in idle
// - Output clock is one sixth CPU rate
// - Enable is bit four of mode register
// - Crystal modes disable both oscillator pins
// - Divider N gives division by 2(N+1), except N=0 which gives division by 1
module osccl_clock_select
  import osccl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [2:0] i_osc_type_strap,
  input wire logic i_power_down,
  input wire logic i_idle,
  input wire logic i_osc_input_port_pin_in,
  output logic o_osc_input_port_pin_out,
  output logic o_osc_input_port_pin_oe_n,
  input wire logic i_osc_output_port_pin_in,
  output logic o_osc_output_clock_pin_out,
  output logic o_osc_output_clock_pin_oe_n,
  input wire logic [1:0] i_gpio_out,
  input wire logic [1:0] i_gpio_oe_n,
  output logic [1:0] o_gpio_in,
  output logic o_cpu_tick,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp
);
  // ==========================================================
  // Assertion clock
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic clk_in_prev;
    logic [1:0] cfg_wait;
    logic cfg_valid;
    osccl_osc_t osc_type;
    logic [7:0] mode_one;
    logic [7:0] divider;
    logic [8:0] div_cnt;
    logic cpu_tick;
    logic [1:0] clk_cnt;
    logic clk_lvl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } osccl_state_t;

  osccl_state_t state_r;
  osccl_state_t state_nxt;
  logic is_xtal;
  logic is_rc;
  logic is_ext;
  logic osc_tick;
  logic clk_on;
  logic [8:0] div_last;
  logic addr_ok;

  always_comb begin
    is_rc = state_r.cfg_valid && state_r.osc_type == OSC_RC;
    is_ext = state_r.cfg_valid && state_r.osc_type == OSC_EXT;
    is_xtal = !is_rc && !is_ext;
    // Oscillator stops in power down
    if (i_power_down) begin
      osc_tick = 1'b0;
    end else if (is_ext) begin
      osc_tick = state_r.pin_s2[1] && !state_r.clk_in_prev;
    end else begin
      osc_tick = 1'b1;
    end
    clk_on = state_r.mode_one[MODE_CLKOUT_BIT] && (is_rc || is_ext) &&
      !i_power_down;
    div_last = {state_r.divider, 1'b1};
    addr_ok = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.strap_s1 = i_osc_type_strap;
    state_nxt.strap_s2 = state_r.strap_s1;
    state_nxt.pin_s1 = {i_osc_input_port_pin_in, i_osc_output_port_pin_in};
    state_nxt.pin_s2 = state_r.pin_s1;
    state_nxt.clk_in_prev = state_r.pin_s2[1];
    // Latch type once the synchronised strap has settled
    if (!state_r.cfg_valid) begin
      if (state_r.cfg_wait == STRAP_SETTLE_LAST) begin
        state_nxt.cfg_valid = 1'b1;
        unique case (state_r.strap_s2)
          STRAP_XTAL_MED: state_nxt.osc_type = OSC_XTAL_MED;
          STRAP_XTAL_HIGH: state_nxt.osc_type = OSC_XTAL_HIGH;
          STRAP_RC: state_nxt.osc_type = OSC_RC;
          STRAP_EXT: state_nxt.osc_type = OSC_EXT;
          default: state_nxt.osc_type = OSC_XTAL_LOW;
        endcase
      end else begin
        state_nxt.cfg_wait = state_r.cfg_wait + 2'h1;
      end
    end
    // CPU clock divider
    state_nxt.cpu_tick = 1'b0;
    if (osc_tick) begin
      if (state_r.divider == DIVIDER_RESET) begin
        state_nxt.div_cnt = '0;
        state_nxt.cpu_tick = 1'b1;
      end else if (state_r.div_cnt >= div_last) begin
        state_nxt.div_cnt = '0;
        state_nxt.cpu_tick = 1'b1;
      end else begin
        state_nxt.div_cnt = state_r.div_cnt + 9'h001;
      end
    end
    // Clock output at one sixth of CPU rate
    if (!clk_on) begin
      state_nxt.clk_cnt = '0;
      state_nxt.clk_lvl = 1'b0;
    end else if (state_r.cpu_tick) begin
      if (state_r.clk_cnt == CLKOUT_HALF_LAST) begin
        state_nxt.clk_cnt = '0;
        state_nxt.clk_lvl = !state_r.clk_lvl;
      end else begin
        state_nxt.clk_cnt = state_r.clk_cnt + 2'h1;
      end
    end
    // Bus slave, zero wait states
    state_nxt.wr_pend = addr_ok && i_hwrite;
    state_nxt.wr_addr = i_haddr[7:0];
    if (state_r.wr_pend) begin
      if (state_r.wr_addr == ADDR_MODE_ONE) begin
        state_nxt.mode_one = i_hwdata[7:0];
      end else if (state_r.wr_addr == ADDR_DIVIDER) begin
        state_nxt.divider = i_hwdata[7:0];
      end
    end
    if (addr_ok && !i_hwrite) begin
      unique case (i_haddr[7:0])
        ADDR_MODE_ONE: state_nxt.rdata = {24'h000000, state_r.mode_one};
        ADDR_DIVIDER: state_nxt.rdata = {24'h000000, state_r.divider};
        ADDR_STATUS: state_nxt.rdata = {26'h0, state_r.clk_lvl,
          clk_on, state_r.cfg_valid, state_r.osc_type};
        default: state_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= '{osc_type: OSC_XTAL_LOW, mode_one: MODE_ONE_RESET,
        divider: DIVIDER_RESET, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Pins
  always_comb begin
    o_gpio_in = '0;
    o_osc_input_port_pin_out = 1'b0;
    o_osc_input_port_pin_oe_n = 1'b1;
    o_osc_output_clock_pin_out = 1'b0;
    o_osc_output_clock_pin_oe_n = 1'b1;
    if (is_xtal) begin
      o_gpio_in = '0;
    end else begin
      o_gpio_in[0] = state_r.pin_s2[0];
      if (clk_on) begin
        o_osc_output_clock_pin_out = state_r.clk_lvl;
        o_osc_output_clock_pin_oe_n = 1'b0;
      end else begin
        o_osc_output_clock_pin_out = i_gpio_out[0];
        o_osc_output_clock_pin_oe_n = i_gpio_oe_n[0];
      end
      if (is_rc) begin
        o_gpio_in[1] = state_r.pin_s2[1];
        o_osc_input_port_pin_out = i_gpio_out[1];
        o_osc_input_port_pin_oe_n = i_gpio_oe_n[1];
      end
    end
  end

  assign o_cpu_tick = state_r.cpu_tick;
  assign o_hrdata = state_r.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ==========================================================
  // Checks
  chk_cfg_locked: assert property (
    state_r.cfg_valid |=> state_r.cfg_valid && $stable(state_r.osc_type))
    else $error("Oscillator type changed after lock");
  chk_xtal_pins: assert property (
    is_xtal |-> o_osc_input_port_pin_oe_n && o_osc_output_clock_pin_oe_n
      && o_gpio_in == 2'h0)
    else $error("Pin active in crystal mode");
  chk_no_xtal_out: assert property (
    is_xtal |-> !clk_on && !state_r.clk_lvl)
    else $error("Clock output in crystal mode");
  chk_pin_drive: assert property (
    clk_on |-> !o_osc_output_clock_pin_oe_n &&
      o_osc_output_clock_pin_out == state_r.clk_lvl)
    else $error("Clock output not driven");
  chk_ext_port: assert property (
    is_ext && !state_r.mode_one[MODE_CLKOUT_BIT] |->
      o_osc_output_clock_pin_out == i_gpio_out[0] &&
      o_osc_output_clock_pin_oe_n == i_gpio_oe_n[0])
    else $error("Output pin not free in external mode");
  chk_ext_pause: assert property (
    is_ext && !osc_tick |=> !state_r.cpu_tick)
    else $error("CPU tick without external edge");
  chk_div_zero: assert property (
    osc_tick && state_r.divider == 8'h00 |=> state_r.cpu_tick)
    else $error("Undivided tick missing");
  chk_div_period: assert property (
    state_r.cpu_tick && is_rc && state_r.divider == 8'h01 && !i_power_down
      ##1 (!state_r.cpu_tick && state_r.divider == 8'h01 &&
      !i_power_down)[*3] ##1 (state_r.divider == 8'h01 && !i_power_down)
      |-> state_r.cpu_tick)
    else $error("Divide by four period wrong");
  chk_out_ratio: assert property (
    clk_on && state_r.cpu_tick && state_r.clk_cnt == 2'h2 ##1 clk_on
      |-> $changed(state_r.clk_lvl))
    else $error("Clock output did not toggle");
  chk_out_hold: assert property (
    !$past(state_r.cpu_tick) && $past(clk_on) |-> $stable(state_r.clk_lvl))
    else $error("Clock output toggled early");
  chk_pd_stop: assert property (
    i_power_down |=> !state_r.clk_lvl && !state_r.cpu_tick)
    else $error("Clock running in power down");

  cov_rc_clkout: cover property (is_rc && clk_on && $rose(state_r.clk_lvl));
  cov_ext_tick: cover property (is_ext && state_r.cpu_tick);
  cov_idle_out: cover property (i_idle && clk_on && $fell(state_r.clk_lvl));
endmodule : osccl_clock_select

// ---- logic/osccl_pkg.sv ----
// Shared constants for the oscillator select and clock output block
package osccl_pkg;
  // ==========================================================
  // Oscillator types, fixed at configuration time
  typedef enum logic [2:0] {
    OSC_XTAL_LOW,
    OSC_XTAL_MED,
    OSC_XTAL_HIGH,
    OSC_RC,
    OSC_EXT
  } osccl_osc_t;
  localparam logic [2:0] STRAP_XTAL_LOW = 3'h0;
  localparam logic [2:0] STRAP_XTAL_MED = 3'h1;
  localparam logic [2:0] STRAP_XTAL_HIGH = 3'h2;
  localparam logic [2:0] STRAP_RC = 3'h3;
  localparam logic [2:0] STRAP_EXT = 3'h4;
  // Last settle count before the synchronised strap is latched
  localparam logic [1:0] STRAP_SETTLE_LAST = 2'h2;
  // ==========================================================
  // Frequency ranges in kHz
  localparam int XTAL_LOW_MIN_KHZ = 20;
  localparam int XTAL_LOW_MAX_KHZ = 100;
  localparam int XTAL_MED_MAX_KHZ = 4000;
  localparam int XTAL_HIGH_MAX_KHZ = 20000;
  localparam int RC_TYP_KHZ = 6000;
  localparam int EXT_MAX_KHZ = 20000;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_MODE_ONE = 8'ha4;
  localparam logic [7:0] ADDR_DIVIDER = 8'ha8;
  localparam logic [7:0] ADDR_STATUS = 8'hac;
  localparam logic [7:0] MODE_ONE_RESET = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam int MODE_CLKOUT_BIT = 4;
  // ==========================================================
  // Clock output ratio: level toggles every third CPU tick
  localparam logic [1:0] CLKOUT_HALF_LAST = 2'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : osccl_pkg

// ---- verification/osccl_ext_source.sv ----
// External clock source model for the oscillator input pin
`timescale 1ns/1ps
module osccl_ext_source (
  input wire logic i_clock,
  input wire logic i_run,
  output logic o_pin
);
  logic [1:0] cnt_r;
  // ==========================================================
  // Clock of eight core cycles; stands low while paused
  always_ff @(posedge i_clock) begin
    if (!i_run) begin
      cnt_r <= 2'h0;
      o_pin <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h3) begin
        o_pin <= !o_pin;
      end
    end
  end
endmodule : osccl_ext_source

// ---- verification/test_oscillator_select_clock_output.sv ----
// Testbench for the oscillator select and clock output block
`timescale 1ns/1ps
module test_oscillator_select_clock_output
  import osccl_pkg::*;
();
  logic clk, rst_n, pd, idle, run, hsel, hwrite, ext_pin;
  logic [2:0] strap;
  logic [1:0] gout, goe_n, gin, htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic in_o, in_oe, pin_o, pin_oe, tick, hrdy, hresp;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  wire logic in_lvl = in_oe ? ext_pin : in_o;
  wire logic out_lvl = pin_oe ? 1'b1 : pin_o;
  osccl_ext_source src (.i_clock(clk), .i_run(run), .o_pin(ext_pin));
  osccl_clock_select dut (.i_clock(clk), .i_reset_n(rst_n),
    .i_osc_type_strap(strap), .i_power_down(pd), .i_idle(idle),
    .i_osc_input_port_pin_in(in_lvl), .o_osc_input_port_pin_out(in_o),
    .o_osc_input_port_pin_oe_n(in_oe), .i_osc_output_port_pin_in(out_lvl),
    .o_osc_output_clock_pin_out(pin_o), .o_osc_output_clock_pin_oe_n(pin_oe),
    .i_gpio_out(gout), .i_gpio_oe_n(goe_n), .o_gpio_in(gin),
    .o_cpu_tick(tick), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp));
  // ==========================================================
  // Clock, timeout and shared tasks
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    q = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic restart(input logic [2:0] s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : restart
  task automatic ticks(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      n += tick;
    end
  endtask : ticks
  task automatic gap();
    logic v;
    @(posedge clk);
    v = pin_o;
    while (pin_o === v) @(posedge clk);
    v = pin_o;
    n = 0;
    while (pin_o === v && n < 100) begin
      @(posedge clk);
      n++;
    end
  endtask : gap
  // ==========================================================
  // Scenarios
  task automatic t_rc();
    restart(STRAP_RC);
    bus(1'b0, ADDR_MODE_ONE, 32'h0);
    check(q, {24'h0, MODE_ONE_RESET});
    bus(1'b0, ADDR_DIVIDER, 32'h0);
    check(q, {24'h0, DIVIDER_RESET});
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(q, 32'h0000000b);
    bus(1'b0, 8'hb0, 32'h0);
    check(q, 32'h0);
    goe_n <= 2'b01;
    gout <= 2'b10;
    ticks(3);
    check({28'h0, in_o, in_oe, gin}, 32'h0000000b);
    bus(1'b1, ADDR_MODE_ONE, 32'h10);
    bus(1'b0, ADDR_MODE_ONE, 32'h0);
    check(q, 32'h10);
    ticks(12);
    check(n, 12);
    gap();
    check(n, 3);
    check({31'h0, pin_oe}, 32'h0);
    idle <= 1'b1;
    gap();
    check(n, 3);
    check({31'h0, pin_oe}, 32'h0);
    bus(1'b1, ADDR_MODE_ONE, 32'h0);
    ticks(1);
    check({30'h0, pin_o, pin_oe}, 32'h1);
    idle <= 1'b0;
    bus(1'b1, ADDR_MODE_ONE, 32'h10);
    bus(1'b1, ADDR_DIVIDER, 32'h1);
    ticks(40);
    check(n, 10);
    bus(1'b0, ADDR_DIVIDER, 32'h0);
    check(q, 32'h1);
    gap();
    check(n, 12);
    pd <= 1'b1;
    ticks(8);
    ticks(20);
    check(n, 0);
    check({30'h0, pin_o, pin_oe}, 32'h1);
    pd <= 1'b0;
    $display("test rc done");
  endtask : t_rc
  task automatic t_xtal();
    logic [2:0] s;
    logic [2:0] typ;
    for (int i = 0; i < 4; i++) begin
      s = (i == 3) ? 3'h5 : i[2:0];
      typ = (i == 3) ? STRAP_XTAL_LOW : i[2:0];
      restart(s);
      bus(1'b1, ADDR_MODE_ONE, 32'h10);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(q, {29'h1, typ});
      check({28'h0, pin_oe, in_oe, gin}, 32'h0000000c);
      ticks(12);
      check(n, 12);
      check({30'h0, pin_o, pin_oe}, 32'h1);
    end
    $display("test xtal done");
  endtask : t_xtal
  task automatic t_ext();
    restart(STRAP_EXT);
    run <= 1'b1;
    goe_n <= 2'b10;
    gout <= 2'b01;
    ticks(16);
    ticks(80);
    check(n, 10);
    check({29'h0, pin_o, pin_oe, gin[0]}, 32'h5);
    bus(1'b1, ADDR_MODE_ONE, 32'h10);
    gap();
    check(n, 24);
    check({31'h0, pin_oe}, 32'h0);
    run <= 1'b0;
    ticks(10);
    ticks(40);
    check(n, 0);
    run <= 1'b1;
    ticks(12);
    ticks(40);
    check(n, 5);
    $display("test ext done");
  endtask : t_ext
  initial begin
    {pd, idle, run, hsel, hwrite} = 5'h0;
    {gout, goe_n, htrans} = 6'h0c;
    haddr = 32'h0;
    hwdata = 32'h0;
    t_rc();
    t_xtal();
    t_ext();
    summarize();
  end
endmodule : test_oscillator_select_clock_output
